// [hw/tfc_pkg.sv]
// Constants and types for the thermal fan configuration register bank
// Overview of operation
// RL1 - Smoothing enable bit 3 makes the PECI-linked PWM ramp instead of jumping.
// RL2 - Range bits 7:4 pick the auto-control temperature span; default code 1100.
// RL3 - After lock, writes to the range and smoothing register are ignored.
// RL4 - A PECI reading above the fail-safe limit forces all PWMs to full duty.
// RL5 - A fail-safe limit of 0x80 disables the PECI full-speed override.
// RL6 - Fail-safe override holds until temperature drops below limit minus hysteresis.
// RL7 - The fail-safe limit register at 0x3D ignores writes once locked.
// RL8 - Revision bits 1:0; all-ones points software to extended revision at 0x12.
// RL9 - Version bits 2 and 3 always read as one.
// RL10 - Version bits 7:4 return a fixed family code.
// RL11 - Monitor-run selects programmed limits; clear uses defaults, keeping programmed values.
// RL12 - Monitor-run stays writable after lock; other lockable config bits freeze.
// RL13 - Monitor-run clear drives all PWMs at full duty.
// RL14 - Lock bit is write-once; only a power cycle (reset) releases it.
// RL15 - Ready bit 2 reads one once the device is up.
// RL16 - Boost bit 3 forces full duty, stays writable after lock.
// RL17 - Bit 4 enables PECI monitoring and locks with the lock bit.
// RL18 - Bit 5 lets overtemp or fail-safe force full duty even in manual mode.
// RL19 - Configuration register resets to 0x04.
// RL20 - Rate bits 2:0 set ramp speed, 000 slowest, 111 fastest.
// RL21 - All full-speed sources are ORed and override any computed or manual duty; fail-safe and overtemp need bit 5 in manual mode.
package tfc_pkg;

  localparam logic [7:0] ADDR_EXT_REV     = 8'h12;
  localparam logic [7:0] ADDR_FAIL_LIMIT  = 8'h3d;
  localparam logic [7:0] ADDR_VERSION     = 8'h3f;
  localparam logic [7:0] ADDR_CONFIG      = 8'h40;
  localparam logic [7:0] ADDR_RANGE_SMOOTH = 8'h60;

  localparam int         CFG_RUN_BIT      = 0;
  localparam int         CFG_LOCK_BIT     = 1;
  localparam int         CFG_RDY_BIT      = 2;
  localparam int         CFG_BOOST_BIT    = 3;
  localparam int         CFG_PECI_BIT     = 4;
  localparam int         CFG_OVERTEMP_INPUT_BIT    = 5;

  localparam int         RS_RATE_LSB      = 0;
  localparam int         RS_SMOOTH_BIT    = 3;
  localparam int         RS_RANGE_LSB     = 4;
  localparam int         VER_REV_LSB      = 0;
  localparam int         VER_PECI_BIT     = 2;
  localparam int         VER_4WIRE_BIT    = 3;
  localparam int         VER_FAMILY_LSB   = 4;

  localparam logic [7:0] CONFIG_RESET     = 8'h04;
  localparam logic [7:0] FAIL_LIMIT_RESET = 8'h00;
  localparam logic [7:0] FAIL_LIMIT_OFF   = 8'h80;
  localparam logic [3:0] RANGE_RESET      = 4'hc;
  localparam logic [2:0] RATE_RESET       = 3'h0;
  localparam logic [1:0] REV_EXTENDED     = 2'h3;
  localparam logic [7:0] DUTY_FULL        = 8'hff;

  // Round-robin refresh that paces each smoothing step
  localparam int         RR_CYCLE_MS      = 165;
  localparam int         CLK_HZ           = 50_000_000;
  localparam int         RR_CYCLES        = RR_CYCLE_MS * (CLK_HZ / 1000);

  typedef struct packed {
    logic [1:0] reserved;
    logic       overtemp_input_man;
    logic       peci_en;
    logic       boost;
    logic       ready;
    logic       lock;
    logic       run;
  } tfc_cfg_type;

  typedef struct packed {
    logic [3:0] range;
    logic       smooth_en;
    logic [2:0] rate;
  } tfc_rs_type;

endpackage

// [hw/tfc_config_regs.sv]
// Configuration, version and fail-safe registers with full-speed override logic
`timescale 1ns/1ps
module tfc_config_regs
  import tfc_pkg::*;
#(
  parameter int         RAMP_TICK_CYCLES = RR_CYCLES,
  parameter logic [1:0] SILICON_REV      = 2'h0,
  parameter logic [7:0] EXT_REV          = 8'h00,
  parameter logic [3:0] FAMILY_CODE      = 4'h9   // Arbitrary value
) (
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic [7:0] i_reg_wdata,
  input  wire logic       i_reg_rd,
  output logic      [7:0] o_reg_rdata,
  input  wire logic [7:0] i_peci_temp,
  input  wire logic       i_peci_valid,
  input  wire logic [7:0] i_hysteresis,
  input  wire logic       i_overtemp_input,
  input  wire logic       i_manual_mode,
  input  wire logic [7:0] i_peci_duty_target,
  output logic      [7:0] o_peci_pwm_duty,
  output logic            o_full_speed,
  output logic            o_use_programmed_limits,
  output logic            o_cpu_thermal_monitor_enable_enable,
  output logic      [3:0] o_range_code
);

  tfc_cfg_type cfg_r, cfg_nxt;
  tfc_rs_type  rs_r, rs_nxt;
  logic [7:0]  limit_r, limit_nxt;
  logic [7:0]  rdata_r, rdata_nxt;
  logic        fs_r, fs_nxt;
  logic        full_r, full_nxt;
  logic [7:0]  duty_r, duty_nxt;
  logic [7:0]  smooth_r, smooth_nxt;
  logic [22:0] tick_cnt_r, tick_cnt_nxt;
  logic        run_r, run_nxt;
  logic        peci_r, peci_nxt;
  logic [3:0]  range_r, range_nxt;

  logic        wr_cfg, wr_rs, wr_lim;
  logic        tick;
  logic [7:0]  step;
  logic [7:0]  version;
  logic        guard_ok;

  assign wr_cfg = i_reg_wr && (i_reg_addr == ADDR_CONFIG);
  assign wr_rs  = i_reg_wr && (i_reg_addr == ADDR_RANGE_SMOOTH);
  assign wr_lim = i_reg_wr && (i_reg_addr == ADDR_FAIL_LIMIT);

  assign version = {FAMILY_CODE, 1'b1, 1'b1, SILICON_REV};  // [RL9] [RL10] [RL8]

  // Register writes
  always_comb begin
    cfg_nxt   = cfg_r;
    rs_nxt    = rs_r;
    limit_nxt = limit_r;
    if (wr_cfg) begin
      cfg_nxt.run   = i_reg_wdata[CFG_RUN_BIT];  // [RL12] [RL11]
      cfg_nxt.boost = i_reg_wdata[CFG_BOOST_BIT];  // [RL16]
      if (!cfg_r.lock) begin
        cfg_nxt.lock      = i_reg_wdata[CFG_LOCK_BIT];  // [RL14]
        cfg_nxt.peci_en   = i_reg_wdata[CFG_PECI_BIT];  // [RL17]
        cfg_nxt.overtemp_input_man = i_reg_wdata[CFG_OVERTEMP_INPUT_BIT];  // [RL18]
      end
    end
    if (wr_rs && !cfg_r.lock) begin  // [RL3]
      rs_nxt.rate      = i_reg_wdata[RS_RATE_LSB +: 3];  // [RL20]
      rs_nxt.smooth_en = i_reg_wdata[RS_SMOOTH_BIT];  // [RL1]
      rs_nxt.range     = i_reg_wdata[RS_RANGE_LSB +: 4];  // [RL2]
    end
    if (wr_lim && !cfg_r.lock) begin  // [RL7]
      limit_nxt = i_reg_wdata;
    end
    cfg_nxt.ready    = 1'b1;  // [RL15]
    cfg_nxt.reserved = 2'h0;
  end

  // Read mux, one cycle after the strobe
  always_comb begin
    rdata_nxt = rdata_r;
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        ADDR_CONFIG:       rdata_nxt = cfg_r;
        ADDR_RANGE_SMOOTH: rdata_nxt = rs_r;
        ADDR_FAIL_LIMIT:   rdata_nxt = limit_r;
        ADDR_VERSION:      rdata_nxt = version;
        ADDR_EXT_REV:      rdata_nxt = EXT_REV;  // [RL8]
        default:           rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cfg_r   <= CONFIG_RESET;  // [RL19] [RL14]
      rs_r    <= {RANGE_RESET, 1'b0, RATE_RESET};  // [RL2]
      limit_r <= FAIL_LIMIT_RESET;
      rdata_r <= 8'h00;
    end else begin
      cfg_r   <= cfg_nxt;
      rs_r    <= rs_nxt;
      limit_r <= limit_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Fail-safe with hysteresis and override combination
  always_comb begin
    fs_nxt = fs_r;
    if (!cfg_r.peci_en || limit_r == FAIL_LIMIT_OFF) begin  // [RL5]
      fs_nxt = 1'b0;
    end else if (i_peci_valid) begin
      if (i_peci_temp > limit_r) begin  // [RL4]
        fs_nxt = 1'b1;
      end else if (({1'b0, i_peci_temp} + {1'b0, i_hysteresis}) < {1'b0, limit_r}) begin  // [RL6]
        fs_nxt = 1'b0;
      end
    end
    guard_ok  = !i_manual_mode || cfg_r.overtemp_input_man;  // [RL18]
    full_nxt  = cfg_r.boost || !cfg_r.run ||
                ((fs_r || i_overtemp_input) && guard_ok);  // [RL21] [RL13] [RL16]
    run_nxt   = cfg_r.run;  // [RL11]
    peci_nxt  = cfg_r.peci_en;
    range_nxt = rs_r.range;
  end

  // Step size per refresh tick
  always_comb begin
    unique case (rs_r.rate)  // [RL20]
      3'h0: step = 8'h01;
      3'h1: step = 8'h02;
      3'h2: step = 8'h03;
      3'h3: step = 8'h04;
      3'h4: step = 8'h08;
      3'h5: step = 8'h0c;
      3'h6: step = 8'h18;
      3'h7: step = 8'h30;
    endcase
  end

  assign tick = (tick_cnt_r == 23'(RAMP_TICK_CYCLES - 1));

  // Duty smoothing
  always_comb begin
    tick_cnt_nxt = tick ? 23'h0 : tick_cnt_r + 23'h1;
    smooth_nxt   = smooth_r;
    if (!rs_r.smooth_en) begin
      smooth_nxt = i_peci_duty_target;
    end else if (tick) begin  // [RL1]
      if (i_peci_duty_target > smooth_r) begin
        smooth_nxt = ((i_peci_duty_target - smooth_r) > step) ? smooth_r + step : i_peci_duty_target;
      end else if (i_peci_duty_target < smooth_r) begin
        smooth_nxt = ((smooth_r - i_peci_duty_target) > step) ? smooth_r - step : i_peci_duty_target;
      end
    end
    duty_nxt = full_r ? DUTY_FULL : smooth_r;  // [RL21]
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      fs_r       <= 1'b0;
      full_r     <= 1'b1;
      duty_r     <= DUTY_FULL;
      smooth_r   <= 8'h00;
      tick_cnt_r <= 23'h0;
      run_r      <= 1'b0;
      peci_r     <= 1'b0;
      range_r    <= RANGE_RESET;
    end else begin
      fs_r       <= fs_nxt;
      full_r     <= full_nxt;
      duty_r     <= duty_nxt;
      smooth_r   <= smooth_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      run_r      <= run_nxt;
      peci_r     <= peci_nxt;
      range_r    <= range_nxt;
    end
  end

  assign o_reg_rdata             = rdata_r;
  assign o_full_speed            = full_r;
  assign o_peci_pwm_duty         = duty_r;
  assign o_use_programmed_limits = run_r;
  assign o_cpu_thermal_monitor_enable_enable   = peci_r;
  assign o_range_code            = range_r;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  a_lock_sticky: assert property (cfg_r.lock |=> cfg_r.lock)  // [RL14]
    else $error("lock bit cleared without reset");
  a_rs_frozen: assert property (cfg_r.lock |=> $stable(rs_r))  // [RL3]
    else $error("range register changed while locked");
  a_limit_frozen: assert property (cfg_r.lock |=> $stable(limit_r))  // [RL7]
    else $error("fail-safe limit changed while locked");
  a_run_writable: assert property (wr_cfg |=> cfg_r.run == $past(i_reg_wdata[CFG_RUN_BIT]))  // [RL12]
    else $error("monitor-run write lost");
  a_peci_frozen: assert property (cfg_r.lock |=> $stable(cfg_r.peci_en) && $stable(cfg_r.overtemp_input_man))  // [RL17]
    else $error("locked config bit changed");
  a_run_full: assert property (!cfg_r.run |-> ##2 o_peci_pwm_duty == DUTY_FULL)  // [RL13]
    else $error("monitor-run clear did not force full duty");
  a_boost_full: assert property (cfg_r.boost |-> ##1 o_full_speed ##1 o_peci_pwm_duty == DUTY_FULL)  // [RL16]
    else $error("boost did not force full duty");
  a_failsafe_off: assert property (limit_r == FAIL_LIMIT_OFF |=> !fs_r)  // [RL5]
    else $error("fail-safe active with disable code");
  a_failsafe_hold: assert property (fs_r && !(i_peci_valid &&
      ({1'b0, i_peci_temp} + {1'b0, i_hysteresis}) < {1'b0, limit_r}) && cfg_r.peci_en &&
      limit_r != FAIL_LIMIT_OFF |=> fs_r)  // [RL6]
    else $error("fail-safe released early");
  a_failsafe_set: assert property (cfg_r.peci_en && limit_r != FAIL_LIMIT_OFF && i_peci_valid &&
      i_peci_temp > limit_r |=> fs_r)  // [RL4]
    else $error("fail-safe did not engage");
  a_manual_gate: assert property (cfg_r.run && !cfg_r.boost && i_manual_mode && !cfg_r.overtemp_input_man
      |=> !full_r)  // [RL18]
    else $error("override forced full in manual without enable");
  a_ready_set: assert property (cfg_r.ready)  // [RL15]
    else $error("ready bit low");
  a_version_bits: assert property (i_reg_rd && i_reg_addr == ADDR_VERSION
      |=> o_reg_rdata[VER_PECI_BIT] && o_reg_rdata[VER_4WIRE_BIT] &&
          o_reg_rdata[VER_FAMILY_LSB +: 4] == FAMILY_CODE)  // [RL9] [RL10]
    else $error("version read wrong");
  a_smooth_step: assert property (rs_r.smooth_en && !tick |=> $stable(smooth_r))  // [RL1]
    else $error("smoothed duty moved between ticks");

  // Writable fields land on the next edge

  a_boost_write: assert property (wr_cfg |=> cfg_r.boost == $past(i_reg_wdata[CFG_BOOST_BIT]))  // [RL16]
    else $error("boost write lost");

  a_lock_once: assert property (!cfg_r.lock && wr_cfg && i_reg_wdata[CFG_LOCK_BIT] |=> cfg_r.lock)  // [RL14]
    else $error("lock write lost");

  a_peci_write: assert property (!cfg_r.lock && wr_cfg
      |=> cfg_r.peci_en == $past(i_reg_wdata[CFG_PECI_BIT]))  // [RL17]
    else $error("monitor enable write lost");

  a_overtemp_input_write: assert property (!cfg_r.lock && wr_cfg
      |=> cfg_r.overtemp_input_man == $past(i_reg_wdata[CFG_OVERTEMP_INPUT_BIT]))  // [RL18]
    else $error("manual override write lost");

  a_rs_write: assert property (!cfg_r.lock && wr_rs |=> rs_r == $past(i_reg_wdata))  // [RL2] [RL1] [RL20]
    else $error("range register write lost");

  a_limit_write: assert property (!cfg_r.lock && wr_lim |=> limit_r == $past(i_reg_wdata))  // [RL7]
    else $error("fail-safe limit write lost");

  a_reserved_zero: assert property (cfg_r.reserved == 2'h0)  // [RL19]
    else $error("reserved config bits set");

  // Read port returns the addressed register

  a_rev_field: assert property (i_reg_rd && i_reg_addr == ADDR_VERSION
      |=> o_reg_rdata[VER_REV_LSB +: 2] == SILICON_REV)  // [RL8]
    else $error("revision field wrong");

  a_ext_rev: assert property (i_reg_rd && i_reg_addr == ADDR_EXT_REV |=> o_reg_rdata == EXT_REV)  // [RL8]
    else $error("extended revision wrong");

  a_cfg_read: assert property (i_reg_rd && i_reg_addr == ADDR_CONFIG |=> o_reg_rdata == $past(cfg_r))  // [RL19]
    else $error("config read wrong");

  a_rdata_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data moved without a read");

  // Override and duty path

  a_full_duty: assert property (full_r |=> o_peci_pwm_duty == DUTY_FULL)  // [RL21]
    else $error("full speed without full duty");

  a_duty_follow: assert property (!full_r |=> o_peci_pwm_duty == $past(smooth_r))  // [RL21]
    else $error("duty does not follow smoothed value");

  a_overtemp_auto: assert property (!i_manual_mode && i_overtemp_input |=> full_r)  // [RL21]
    else $error("overtemp did not force full speed");

  a_failsafe_peci: assert property (!cfg_r.peci_en |=> !fs_r)  // [RL4]
    else $error("fail-safe active without monitoring");

  a_failsafe_release: assert property (fs_r && cfg_r.peci_en && limit_r != FAIL_LIMIT_OFF && i_peci_valid &&
      ({1'b0, i_peci_temp} + {1'b0, i_hysteresis}) < {1'b0, limit_r} |=> !fs_r)  // [RL6]
    else $error("fail-safe did not release");

  // Smoothing ramp moves toward the target, never past it

  a_smooth_bypass: assert property (!rs_r.smooth_en |=> smooth_r == $past(i_peci_duty_target))  // [RL1]
    else $error("unsmoothed duty not passed through");

  a_smooth_up: assert property (rs_r.smooth_en && tick && i_peci_duty_target > smooth_r
      |=> smooth_r > $past(smooth_r) && smooth_r <= $past(i_peci_duty_target))  // [RL1] [RL20]
    else $error("ramp up overshot or stalled");

  a_smooth_down: assert property (rs_r.smooth_en && tick && i_peci_duty_target < smooth_r
      |=> smooth_r < $past(smooth_r) && smooth_r >= $past(i_peci_duty_target))  // [RL1] [RL20]
    else $error("ramp down overshot or stalled");

  a_tick_wrap: assert property (tick |=> tick_cnt_r == 23'h0)
    else $error("refresh counter did not wrap");

  // Registered status copies

  a_mirror_out: assert property (1'b1 |=> o_use_programmed_limits == $past(cfg_r.run) &&
      o_cpu_thermal_monitor_enable_enable == $past(cfg_r.peci_en) && o_range_code == $past(rs_r.range))  // [RL11] [RL17]
    else $error("status copy wrong");

endmodule // tfc_config_regs

// [tb/tfc_host_model.sv]
// Register port host model driving strobes and collecting read data
`timescale 1ns/1ps
module tfc_host_model (
  input  wire logic       i_mclk,
  input  wire logic [7:0] i_reg_rdata,
  output logic      [7:0] o_reg_addr,
  output logic            o_reg_wr,
  output logic      [7:0] o_reg_wdata,
  output logic            o_reg_rd
);
  initial begin
    o_reg_addr  = 8'h00;
    o_reg_wr    = 1'b0;
    o_reg_wdata = 8'h00;
    o_reg_rd    = 1'b0;
  end
  // Released lines show the inverse so stale values never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    o_reg_addr  <= a;
    o_reg_wdata <= d;
    o_reg_wr    <= 1'b1;
    @(posedge i_mclk);
    o_reg_wr    <= 1'b0;
    o_reg_addr  <= ~a;
    o_reg_wdata <= ~d;
  endtask
  // Data registered at the read edge, sampled mid-cycle after it
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    o_reg_addr <= a;
    o_reg_rd   <= 1'b1;
    @(posedge i_mclk);
    o_reg_rd   <= 1'b0;
    o_reg_addr <= ~a;
    @(negedge i_mclk);
    d = i_reg_rdata;
  endtask
endmodule // tfc_host_model

// [tb/thermal_fan_config_registers_tb.sv]
// Self-checking bench for the thermal fan configuration registers
`timescale 1ns/1ps
module thermal_fan_config_registers_tb;
  import tfc_pkg::*;
  localparam logic [3:0] FAM  = 4'h5;   // Arbitrary value
  localparam logic [7:0] XREV = 8'h21;
  logic       i_mclk, i_rst, i_reg_wr, i_reg_rd, i_peci_valid, i_overtemp_input, i_manual_mode;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, i_peci_temp, i_hysteresis, i_peci_duty_target;
  logic [7:0] o_peci_pwm_duty, rv;
  logic       o_full_speed, o_use_programmed_limits, o_cpu_thermal_monitor_enable_enable;
  logic [3:0] o_range_code;
  int         errors, checks_done, cyc;

  tfc_config_regs #(.RAMP_TICK_CYCLES(4), .SILICON_REV(2'h3), .EXT_REV(XREV), .FAMILY_CODE(FAM))
  tfc_config_regs_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
    .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_peci_temp(i_peci_temp),
    .i_peci_valid(i_peci_valid), .i_hysteresis(i_hysteresis), .i_overtemp_input(i_overtemp_input),
    .i_manual_mode(i_manual_mode), .i_peci_duty_target(i_peci_duty_target),
    .o_peci_pwm_duty(o_peci_pwm_duty), .o_full_speed(o_full_speed),
    .o_use_programmed_limits(o_use_programmed_limits), .o_cpu_thermal_monitor_enable_enable(o_cpu_thermal_monitor_enable_enable),
    .o_range_code(o_range_code));

  tfc_host_model tfc_host_model_inst (.i_mclk(i_mclk), .i_reg_rdata(o_reg_rdata), .o_reg_addr(i_reg_addr),
    .o_reg_wr(i_reg_wr), .o_reg_wdata(i_reg_wdata), .o_reg_rd(i_reg_rd));

  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  task automatic final_report();
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      final_report();
    end
  end

  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp1(input logic g, input logic e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    tfc_host_model_inst.wr(a, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    tfc_host_model_inst.rd(a, rv);
    cmp8(rv, e);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge i_mclk);
    @(negedge i_mclk);
  endtask
  task automatic setin(input logic [7:0] t, input logic ot, input logic man, input logic [7:0] tgt);
    @(posedge i_mclk);
    i_peci_temp        <= t;
    i_overtemp_input   <= ot;
    i_manual_mode      <= man;
    i_peci_duty_target <= tgt;
  endtask

  initial begin
    i_rst = 1'b1;
    i_peci_valid = 1'b1;
    i_hysteresis = 8'h08;
    i_peci_temp = 8'h00;
    i_overtemp_input = 1'b0;
    i_manual_mode = 1'b0;
    i_peci_duty_target = 8'h00;
    repeat (8) @(posedge i_mclk);
    i_rst <= 1'b0;
    settle(1);
    cmp1(o_full_speed, 1'b1);
    cmp8({4'h0, o_range_code}, 8'h0c);
    cmp1(o_use_programmed_limits, 1'b0);
    rchk(ADDR_CONFIG, CONFIG_RESET);
    rchk(ADDR_FAIL_LIMIT, FAIL_LIMIT_RESET);
    w(ADDR_VERSION, 8'h00);
    rchk(ADDR_VERSION, {FAM, 1'b1, 1'b1, 2'h3});
    rchk(ADDR_EXT_REV, XREV);
    rchk(ADDR_RANGE_SMOOTH, 8'hc0);
    rchk(8'h55, 8'h00);
    // Run, then boost on and off
    w(ADDR_CONFIG, 8'h01);
    settle(4);
    cmp1(o_full_speed, 1'b0);
    cmp1(o_use_programmed_limits, 1'b1);
    cmp8(o_peci_pwm_duty, 8'h00);
    w(ADDR_CONFIG, 8'h09);
    settle(4);
    cmp8(o_peci_pwm_duty, DUTY_FULL);
    w(ADDR_CONFIG, 8'h01);
    settle(4);
    cmp1(o_full_speed, 1'b0);
    w(ADDR_RANGE_SMOOTH, 8'h37);
    rchk(ADDR_RANGE_SMOOTH, 8'h37);
    cmp8({4'h0, o_range_code}, 8'h03);
    // Slowest ramp up, then fastest ramp down
    w(ADDR_RANGE_SMOOTH, 8'hc8);
    setin(8'h00, 1'b0, 1'b0, 8'h40);
    settle(6);
    cmp1(o_peci_pwm_duty < 8'h40, 1'b1);
    settle(300);
    cmp8(o_peci_pwm_duty, 8'h40);
    w(ADDR_RANGE_SMOOTH, 8'hcf);
    setin(8'h00, 1'b0, 1'b0, 8'h00);
    settle(20);
    cmp8(o_peci_pwm_duty, 8'h00);
    // Fail-safe limit with hysteresis
    w(ADDR_CONFIG, 8'h11);
    w(ADDR_FAIL_LIMIT, 8'h50);
    settle(2);
    cmp1(o_cpu_thermal_monitor_enable_enable, 1'b1);
    setin(8'h51, 1'b0, 1'b0, 8'h00);
    settle(4);
    cmp1(o_full_speed, 1'b1);
    setin(8'h49, 1'b0, 1'b0, 8'h00);
    settle(4);
    cmp1(o_full_speed, 1'b1);
    setin(8'h47, 1'b0, 1'b0, 8'h00);
    settle(4);
    cmp1(o_full_speed, 1'b0);
    w(ADDR_FAIL_LIMIT, FAIL_LIMIT_OFF);
    setin(8'hff, 1'b0, 1'b0, 8'h00);
    settle(4);
    cmp1(o_full_speed, 1'b0);
    setin(8'h00, 1'b1, 1'b0, 8'h00);
    settle(4);
    cmp1(o_full_speed, 1'b1);
    setin(8'h00, 1'b1, 1'b1, 8'h00);
    settle(4);
    cmp1(o_full_speed, 1'b0);
    w(ADDR_CONFIG, 8'h31);
    settle(4);
    cmp1(o_full_speed, 1'b1);
    // Lock, then attempt to change everything
    setin(8'h00, 1'b0, 1'b0, 8'h00);
    w(ADDR_FAIL_LIMIT, 8'h60);
    w(ADDR_CONFIG, 8'h13);
    w(ADDR_RANGE_SMOOTH, 8'h00);
    rchk(ADDR_RANGE_SMOOTH, 8'hcf);
    w(ADDR_FAIL_LIMIT, 8'h10);
    rchk(ADDR_FAIL_LIMIT, 8'h60);
    w(ADDR_CONFIG, 8'h28);
    rchk(ADDR_CONFIG, 8'h1e);
    settle(4);
    cmp1(o_cpu_thermal_monitor_enable_enable, 1'b1);
    cmp1(o_full_speed, 1'b1);
    // Power cycle releases the lock
    @(posedge i_mclk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'b0;
    settle(1);
    rchk(ADDR_CONFIG, CONFIG_RESET);
    w(ADDR_FAIL_LIMIT, 8'h22);
    rchk(ADDR_FAIL_LIMIT, 8'h22);
    final_report();
  end
endmodule // thermal_fan_config_registers_tb
